// File: dv/bmx_exec_assertions.sv
`default_nettype none
module bmx_exec_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_rdata,
	input wire logic        mem_rfsh,
	input wire logic        irq_ack,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready
);
	// Single domain, reset masks every check
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// First refresh pulse of a pair
	sequence s_rfsh_first;
		mem_rfsh && !$past(mem_rfsh, 2);
	endsequence
	// Gap, then the second pulse
	sequence s_rfsh_tail;
		!mem_rfsh ##1 mem_rfsh;
	endsequence
	AST_RFSH_PAIR: assert property (s_rfsh_first |=> s_rfsh_tail)
		else $error("refresh pulses not paired");
	AST_RFSH_QUIET: assert property (mem_rfsh |-> !mem_rd && !mem_wr)
		else $error("refresh overlaps a data cycle");
	AST_RFSH_AFTER_RD: assert property (s_rfsh_first |-> $past(mem_rd, 7))
		else $error("refresh not seven states after the read");
	AST_WR_SLOT: assert property (mem_wr
		|-> $past(mem_rd, 5) || $past(mem_rd, 3) || $past(mem_wr, 5))
		else $error("write strobe in a wrong clock state");
	AST_SWAP_RD_ADDR: assert property (mem_rd && $past(mem_rd, 4)
		|-> mem_addr == $past(mem_addr, 4) + 16'h0001)
		else $error("second stack read not at next address");
	AST_SWAP_WR_ADDR: assert property (mem_wr && $past(mem_wr, 5)
		|-> mem_addr == $past(mem_addr, 12) && mem_addr == $past(mem_addr, 5) - 16'h0001)
		else $error("stack writes at wrong addresses");
	AST_MOVE_DATA: assert property (mem_wr && $past(mem_rd, 5)
		|-> mem_wdata == $past(mem_rdata, 5))
		else $error("moved byte differs from byte read");
	AST_IRQ_SLOT: assert property (irq_ack
		|-> $past(mem_rfsh, 1) || $past(mem_rfsh, 2) || $past(mem_rfsh, 3))
		else $error("interrupt taken away from an iteration boundary");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
endmodule
bind bmx_exec bmx_exec_checker i_chk (.aclk, .aresetn, .mem_addr, .mem_wdata, .mem_rd, .mem_wr,
	.mem_rdata, .mem_rfsh, .irq_ack, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// File: dv/bmx_mem_model.sv
`default_nettype none
module bmx_mem_model (
	input  wire logic        aclk,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	output logic [7:0]       mem_rdata
);
	logic [7:0] mem [65536];	// Byte store, loaded by the bench
	logic [7:0] idle_q = 8'h5A;	// Junk driven while not read

	// Write strobe stores a byte; idle bus shows the inverse of its last value
	always @(posedge aclk) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
		idle_q <= ~mem_rdata;
	end

	// Combinational read, only valid during the read strobe
	assign mem_rdata = mem_rd ? mem[mem_addr] : idle_q;
endmodule
`default_nettype wire

// File: dv/tb_block_move_search_exec.sv
`default_nettype none
module tb_block_move_search_exec import bmx_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'h0, aresetn = 1'h0, irq_req = 1'h0;	// Clock, reset, interrupt
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd, st;
	logic [15:0] mem_addr, m_src, m_dst, m_cnt, m_iy, m_sp, m_pc;	// Reference pairs
	logic [7:0]  mem_wdata, mem_rdata, m_acc, m_f;
	logic        mem_rd, mem_wr, mem_rfsh, irq_ack;
	logic [7:0]  exp_mem [65536];	// Reference memory
	logic [7:0]  opc [3] = '{BMX_OP_MVI, BMX_OP_MVD, BMX_OP_SCI};
	int          failures = 0, n_checks = 0, seed = 32'h8DC7ABEC, i, k;

	bmx_exec i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata, .mem_rfsh, .irq_req,
		.irq_ack);
	bmx_mem_model i_mem (.aclk, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata);

	// 40 ns clock
	always #20 aclk = ~aclk;

	// Verdict and end of run
	task automatic stop_test;
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	// Wait ran out
	task automatic hang;
		failures++;
		$display("Error at %0t: wait timed out", $time);
		stop_test();
	endtask
	// Bus write, both channels offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
			s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
			if (s_axi_bvalid)
				break;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (n == 50)
			hang();
	endtask
	// Bus read
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			s_axi_arvalid <= s_axi_arvalid & ~s_axi_arready;
			if (s_axi_rvalid)
				break;
		end
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (n == 50)
			hang();
	endtask
	// Random register contents
	task automatic rnd;
		{m_src, m_dst} = $random(seed);
		{m_iy, m_sp} = $random(seed);
		{m_pc, m_acc, m_f} = $random(seed);
	endtask
	// Reference registers into the design, opcode start, wait for idle
	task automatic run(input logic [15:0] op);
		int n;
		axw(BMX_OFS_SRC, {16'h0, m_src});
		axw(BMX_OFS_DST, {16'h0, m_dst});
		axw(BMX_OFS_CNT, {16'h0, m_cnt});
		axw(BMX_OFS_IDXY, {16'h0, m_iy});
		axw(BMX_OFS_STACK, {16'h0, m_sp});
		axw(BMX_OFS_ACCF, {16'h0, m_acc, m_f});
		axw(BMX_OFS_PC, {16'h0, m_pc});
		axw(BMX_OFS_CTRL, {16'h0, op});
		for (n = 0; n < 400; n++) begin
			axr(BMX_OFS_STATUS, st);
			if (!st[BMX_ST_BUSY])
				break;
		end
		if (n == 400)
			hang();
	endtask
	// One pass of the reference: k 0 move up, 1 move down, 2 search up
	task automatic mstep(input int k, output bit more);
		logic [7:0] m, r;
		m = exp_mem[m_src];
		r = m_acc - m;
		if (k < 2) begin
			exp_mem[m_dst] = m;
			m_dst = (k == 1) ? m_dst - 16'h1 : m_dst + 16'h1;
			m_f = (m_f & 8'hE9) | {5'h0, m_cnt != 16'h1, 2'h0};
		end else begin
			m_f = (m_f & 8'h29) | {r[7], m_acc == m, 1'h0, m_acc[3:0] < m[3:0], 1'h0,
				m_cnt != 16'h1, 2'h2};
		end
		m_src = (k == 1) ? m_src - 16'h1 : m_src + 16'h1;
		m_cnt = m_cnt - 16'h1;
		m_pc = m_pc + 16'h2;
		more = m_cnt != 16'h0 && !(k == 2 && m == m_acc);
	endtask
	// Whole instruction; a pending interrupt ends it after one pass
	task automatic mrun(input int k, input bit rpt);
		bit more;
		do begin
			mstep(k, more);
			if (rpt && more)
				m_pc = m_pc - BMX_PC_BACK;
		end while (rpt && more && !irq_req);
	endtask
	// Registers, pass length and memory against the reference
	task automatic cmp(input logic [4:0] t);
		int a;
		chk(st[20:16], t);
		axr(BMX_OFS_SRC, rd);
		chk(rd[15:0], m_src);
		axr(BMX_OFS_DST, rd);
		chk(rd[15:0], m_dst);
		axr(BMX_OFS_CNT, rd);
		chk(rd[15:0], m_cnt);
		axr(BMX_OFS_IDXY, rd);
		chk(rd[15:0], m_iy);
		axr(BMX_OFS_STACK, rd);
		chk(rd[15:0], m_sp);
		axr(BMX_OFS_ACCF, rd);
		chk(rd[15:0], {m_acc, m_f});
		axr(BMX_OFS_PC, rd);
		chk(rd[15:0], m_pc);
		for (a = 0; a < 65536; a++)
			chk(i_mem.mem[a], exp_mem[a]);
	endtask

	// Main sequence
	initial begin
		for (i = 0; i < 65536; i++) begin
			exp_mem[i] = 8'($random(seed));
			i_mem.mem[i] = exp_mem[i];
		end
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		// Unmapped place refused
		axw(8'hFC, 32'h0);
		chk(resp, 2'h2);
		axr(8'hFC, rd);
		chk(resp, 2'h2);
		// Unknown opcode flags an error and does not run
		axw(BMX_OFS_CTRL, {16'h0, BMX_PFX_ED, 8'hA9});
		axr(BMX_OFS_STATUS, st);
		chk(st[2:0], 3'h2);
		// Stack-top swap with index Y
		rnd();
		m_cnt = 16'h1234;
		run({BMX_PFX_IY, BMX_OP_SWAP});
		{m_iy, exp_mem[m_sp + 16'h1], exp_mem[m_sp]} = {exp_mem[m_sp + 16'h1], exp_mem[m_sp], m_iy};
		m_pc = m_pc + 16'h2;
		cmp(5'd23);
		// Single steps, count of one first
		for (i = 0; i < 6; i++) begin
			k = i % 3;
			rnd();
			m_cnt = (i < 3) ? 16'h1 : 16'($random(seed));
			run({BMX_PFX_ED, opc[k]});
			mrun(k, 1'h0);
			cmp(5'd16);
		end
		// Repeats to completion, search meets its byte early
		for (k = 0; k < 3; k++) begin
			rnd();
			m_cnt = 16'h5;
			exp_mem[m_src + 16'h2] = m_acc;
			i_mem.mem[m_src + 16'h2] = m_acc;
			run({BMX_PFX_ED, opc[k] | 8'h10});
			mrun(k, 1'h1);
			cmp(5'd16);
		end
		// Zero start count, interrupt stops after one pass
		irq_req <= 1'h1;
		for (k = 0; k < 3; k += 2) begin
			rnd();
			m_cnt = 16'h0;
			m_acc = ~exp_mem[m_src];
			run({BMX_PFX_ED, opc[k] | 8'h10});
			mrun(k, 1'h1);
			cmp(5'd21);
		end
		stop_test();
	end
endmodule
`default_nettype wire

// File: include/bmx_pkg.sv
// Functional notes
// - Prefix FD E3 swaps index Y with stack
// - Swap: six cycles, 4,4,3,4,3,5, flags kept
// - ED A0 copies byte, pointers up, counter down
// - Single steps take 4,4,3,5 clock states
// - ED B0 repeats via program counter minus two
// - Repeats take interrupts, two refreshes per continuing iteration
// - Zero start count moves the full 64KB
// - Continuing repeat iteration: 4,4,3,5,5 states
// - ED A8 copies byte, all three pairs down
// - ED B8 repeats decrementing move until zero
// - ED A1 compares accumulator, pointer up, counter down
// - Compare leaves accumulator and memory unchanged
// - Compare sets S,Z,H,P/V,N and keeps carry
// - ED B1 repeats until zero count or match
// - Zero start count searches the full 64KB
`default_nettype none
package bmx_pkg;
	// Register byte offsets
	localparam logic [7:0] BMX_OFS_CTRL   = 8'h00;
	localparam logic [7:0] BMX_OFS_STATUS = 8'h04;
	localparam logic [7:0] BMX_OFS_SRC    = 8'h08;
	localparam logic [7:0] BMX_OFS_DST    = 8'h0C;
	localparam logic [7:0] BMX_OFS_CNT    = 8'h10;
	localparam logic [7:0] BMX_OFS_IDXY   = 8'h14;
	localparam logic [7:0] BMX_OFS_STACK  = 8'h18;
	localparam logic [7:0] BMX_OFS_ACCF   = 8'h1C;
	localparam logic [7:0] BMX_OFS_PC     = 8'h20;
	// Opcode bytes
	localparam logic [7:0] BMX_PFX_IY   = 8'hFD;
	localparam logic [7:0] BMX_PFX_ED   = 8'hED;
	localparam logic [7:0] BMX_OP_SWAP  = 8'hE3;
	localparam logic [7:0] BMX_OP_MVI   = 8'hA0;
	localparam logic [7:0] BMX_OP_MVD   = 8'hA8;
	localparam logic [7:0] BMX_OP_SCI   = 8'hA1;
	localparam logic [7:0] BMX_OP_MVIR  = 8'hB0;
	localparam logic [7:0] BMX_OP_MVDR  = 8'hB8;
	localparam logic [7:0] BMX_OP_SCIR  = 8'hB1;
	// Flag bit positions
	localparam int BMX_F_S  = 7;
	localparam int BMX_F_Z  = 6;
	localparam int BMX_F_H  = 4;
	localparam int BMX_F_PV = 2;
	localparam int BMX_F_N  = 1;
	localparam int BMX_F_C  = 0;
	// Status bit positions
	localparam int BMX_ST_BUSY = 0;
	localparam int BMX_ST_ERR  = 1;
	localparam int BMX_ST_IRQ  = 2;
	// Clock states per machine cycle, swap and block forms
	localparam logic [2:0] BMX_T_SWAP [6] = '{3'h4, 3'h4, 3'h3, 3'h4, 3'h3, 3'h5};
	localparam logic [2:0] BMX_T_BLK  [5] = '{3'h4, 3'h4, 3'h3, 3'h5, 3'h5};
	// Last machine cycle index
	localparam logic [2:0] BMX_MC_SWAP_LAST = 3'h5;
	localparam logic [2:0] BMX_MC_BLK_DONE  = 3'h3;
	localparam logic [2:0] BMX_MC_BLK_RPT   = 3'h4;
	// Program counter step back on repeat
	localparam logic [15:0] BMX_PC_BACK = 16'h0002;
	// Operation kinds
	typedef enum logic [1:0] {
		BMX_K_SWAP = 2'b00,
		BMX_K_MVI  = 2'b01,
		BMX_K_MVD  = 2'b10,
		BMX_K_SCI  = 2'b11
	} bmx_kind_t;
	// Sequencer states
	typedef enum logic [0:0] {
		BMX_S_IDLE = 1'b0,
		BMX_S_RUN  = 1'b1
	} bmx_state_t;
endpackage
`default_nettype wire

// File: rtl/bmx_exec.sv
`default_nettype none
module bmx_exec
	import bmx_pkg::*;
#(
	parameter int ADDR_W = 8	// AXI address width
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic [15:0]             mem_addr,
	output logic [7:0]              mem_wdata,
	output logic                    mem_rd,
	output logic                    mem_wr,
	input  wire logic [7:0]         mem_rdata,
	output logic                    mem_rfsh,
	input  wire logic               irq_req,
	output logic                    irq_ack
);
	// Elaboration check on address width
	if (ADDR_W < 6) begin : g_chk
		$error("ADDR_W too small for register map");
	end

	bmx_state_t     state_reg;	// Sequencer state
	bmx_kind_t      kind_reg;	// Operation in flight
	logic           rpt_reg;	// Repeating form
	logic [2:0]     mc_reg;	// Machine cycle index
	logic [2:0]     t_reg;	// Clock state within cycle
	logic [15:0]    src_reg;	// Source pointer pair
	logic [15:0]    dst_reg;	// Target pointer pair
	logic [15:0]    cnt_reg;	// Byte counter pair
	logic [15:0]    iy_reg;	// Index register Y
	logic [15:0]    sp_reg;	// Stack pointer
	logic [15:0]    pc_reg;	// Program counter
	logic [7:0]     acc_reg;	// Accumulator
	logic [7:0]     flg_reg;	// Condition flags
	logic [7:0]     lo_reg;	// Fetched low byte / moved byte
	logic [7:0]     hi_reg;	// Fetched high byte
	logic [4:0]     tsum_reg;	// States of last iteration
	logic           err_reg;	// Unknown opcode flag
	logic           aw_reg;	// Write address held
	logic           w_reg;	// Write data held
	logic [ADDR_W-1:0] awa_reg;	// Held write address
	logic [31:0]    wd_reg;	// Held write data
	logic [3:0]     ws_reg;	// Held write strobes
	logic           bv_reg;	// Write response pending
	logic [1:0]     br_reg;	// Write response code
	logic           rv_reg;	// Read data pending
	logic [31:0]    rd_reg;	// Read data
	logic [1:0]     rr_reg;	// Read response code
	logic           ack_reg;	// Interrupt taken pulse

	// Sequencer decode
	wire busy      = (state_reg == BMX_S_RUN);
	wire is_swap   = (kind_reg == BMX_K_SWAP);
	wire is_cmp    = (kind_reg == BMX_K_SCI);
	wire [2:0] tlen = is_swap ? BMX_T_SWAP[mc_reg] : BMX_T_BLK[mc_reg];
	wire mc_end    = busy && (t_reg == tlen);
	wire blk       = busy && !is_swap;
	// Counter decrement; zero start wraps to FFFF so the full space runs
	wire [15:0] cnt_dec = cnt_reg - 16'h0001;
	wire cnt_nz    = (cnt_dec != 16'h0000);
	// Compare arithmetic, result is discarded
	wire [7:0] diff = acc_reg - lo_reg;
	wire cmp_eq    = (acc_reg == lo_reg);
	wire half_brw  = (acc_reg[3:0] < lo_reg[3:0]);
	// Repeat continues on nonzero count, compares also stop on match
	wire go_on     = rpt_reg && cnt_nz && !(is_cmp && cmp_eq);
	wire step_up   = (kind_reg != BMX_K_MVD);
	wire [15:0] src_nxt = step_up ? src_reg + 16'h0001 : src_reg - 16'h0001;
	wire [15:0] dst_nxt = step_up ? dst_reg + 16'h0001 : dst_reg - 16'h0001;
	wire last_mc   = is_swap ? (mc_reg == BMX_MC_SWAP_LAST)
		: (mc_reg == BMX_MC_BLK_RPT) || (mc_reg == BMX_MC_BLK_DONE && !go_on);
	// Flags for moves and compares
	wire [7:0] f_mv;
	wire [7:0] f_cp;
	// Moves keep S, Z, C and spare bits; H, N cleared; P/V only from the count
	assign f_mv = (flg_reg & ~((8'h01 << BMX_F_H) | (8'h01 << BMX_F_N) | (8'h01 << BMX_F_PV)))
		| ({7'h00, cnt_nz} << BMX_F_PV);
	assign f_cp = ({7'h00, diff[7]} << BMX_F_S) | ({7'h00, cmp_eq} << BMX_F_Z)
		| ({7'h00, half_brw} << BMX_F_H) | ({7'h00, cnt_nz} << BMX_F_PV)
		| (8'h01 << BMX_F_N) | (flg_reg & 8'h01 << BMX_F_C) | (flg_reg & 8'h28);

	// Memory port strobes
	wire rd_swp = is_swap && (mc_reg == 3'h2 || mc_reg == 3'h3);
	wire wr_swp = is_swap && (mc_reg == 3'h4 || mc_reg == 3'h5);
	assign mem_rd    = mc_end && (rd_swp || (!is_swap && mc_reg == 3'h2));
	assign mem_wr    = mc_end && (wr_swp || (!is_swap && !is_cmp && mc_reg == 3'h3));
	assign mem_addr  = is_swap ? ((mc_reg == 3'h3 || mc_reg == 3'h4) ? sp_reg + 16'h0001 : sp_reg)
		: (mc_reg == 3'h3 ? dst_reg : src_reg);
	assign mem_wdata = is_swap ? (mc_reg == 3'h4 ? iy_reg[15:8] : iy_reg[7:0]) : lo_reg;
	// Two refresh strobes in the extra repeat cycle
	assign mem_rfsh  = blk && (mc_reg == BMX_MC_BLK_RPT) && (t_reg == 3'h2 || t_reg == 3'h4);
	assign irq_ack   = ack_reg;

	// AXI decode
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_reg || aw_take;
	wire w_have  = w_reg || w_take;
	wire do_wr   = aw_have && w_have && !bv_reg;
	wire [ADDR_W-1:0] wa = aw_reg ? awa_reg : s_axi_awaddr;
	wire [31:0] wd = w_reg ? wd_reg : s_axi_wdata;
	wire [3:0] ws = w_reg ? ws_reg : s_axi_wstrb;	// Strobes travel with their data
	wire [7:0] wa8 = 8'(wa);
	wire [7:0] ra8 = 8'(s_axi_araddr);
	wire wmap = (wa8 <= BMX_OFS_PC) && (wa8[1:0] == 2'b00) && (wa[ADDR_W-1:2] < 9);
	wire w_ok = do_wr && wmap && (wa8 != BMX_OFS_STATUS);
	wire sw   = w_ok && !busy;	// Writes while running are ignored
	wire [15:0] wd16 = {ws[1] ? wd[15:8] : 8'h00, ws[0] ? wd[7:0] : 8'h00};
	wire [7:0] pfx = wd[15:8];
	wire [7:0] opc = wd[7:0];
	wire dec_swp = (pfx == BMX_PFX_IY) && (opc == BMX_OP_SWAP);
	wire dec_ed  = (pfx == BMX_PFX_ED) && (opc == BMX_OP_MVI || opc == BMX_OP_MVD
		|| opc == BMX_OP_SCI || opc == BMX_OP_MVIR || opc == BMX_OP_MVDR || opc == BMX_OP_SCIR);
	wire start   = sw && (wa8 == BMX_OFS_CTRL) && (&ws[1:0]);
	wire dec_ok  = dec_swp || dec_ed;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	assign s_axi_awready = !aw_reg && !bv_reg;
	assign s_axi_wready  = !w_reg && !bv_reg;
	assign s_axi_arready = !rv_reg;
	assign s_axi_bvalid  = bv_reg;
	assign s_axi_bresp   = br_reg;
	assign s_axi_rvalid  = rv_reg;
	assign s_axi_rdata   = rd_reg;
	assign s_axi_rresp   = rr_reg;
	// Read mux
	wire [31:0] status = {11'h000, tsum_reg, 13'h0000, ack_reg, err_reg, busy};
	logic [31:0] rmux;
	logic        rmiss;
	always_comb begin
		rmiss = 1'b0;
		case (ra8)
			BMX_OFS_CTRL:   rmux = {24'h000000, 5'h00, rpt_reg, kind_reg};
			BMX_OFS_STATUS: rmux = status;
			BMX_OFS_SRC:    rmux = {16'h0000, src_reg};
			BMX_OFS_DST:    rmux = {16'h0000, dst_reg};
			BMX_OFS_CNT:    rmux = {16'h0000, cnt_reg};
			BMX_OFS_IDXY:   rmux = {16'h0000, iy_reg};
			BMX_OFS_STACK:  rmux = {16'h0000, sp_reg};
			BMX_OFS_ACCF:   rmux = {16'h0000, acc_reg, flg_reg};
			BMX_OFS_PC:     rmux = {16'h0000, pc_reg};
			default: begin
				rmux  = 32'h00000000;
				rmiss = 1'b1;
			end
		endcase
		if (s_axi_araddr[ADDR_W-1:2] >= 9) begin
			rmux  = 32'h00000000;
			rmiss = 1'b1;
		end
	end

	// AXI channel holding and responses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_reg  <= 1'b0;
			w_reg   <= 1'b0;
			awa_reg <= '0;
			wd_reg  <= 32'h00000000;
			ws_reg  <= 4'h0;
			bv_reg  <= 1'b0;
			br_reg  <= 2'b00;
			rv_reg  <= 1'b0;
			rd_reg  <= 32'h00000000;
			rr_reg  <= 2'b00;
		end else begin
			if (aw_take) begin
				awa_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				wd_reg <= s_axi_wdata;
				ws_reg <= s_axi_wstrb;
			end
			aw_reg <= do_wr ? 1'b0 : aw_have;
			w_reg  <= do_wr ? 1'b0 : w_have;
			if (do_wr) begin
				bv_reg <= 1'b1;
				br_reg <= wmap ? 2'b00 : 2'b10;	// SLVERR when unmapped
			end else if (s_axi_bready) begin
				bv_reg <= 1'b0;
			end
			if (ar_take) begin
				rv_reg <= 1'b1;
				rd_reg <= rmux;
				rr_reg <= rmiss ? 2'b10 : 2'b00;
			end else if (s_axi_rready) begin
				rv_reg <= 1'b0;
			end
		end
	end

	// Sequencer: clock states and machine cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= BMX_S_IDLE;
			kind_reg  <= BMX_K_SWAP;
			rpt_reg   <= 1'b0;
			mc_reg    <= 3'h0;
			t_reg     <= 3'h1;
			tsum_reg  <= 5'h00;
			err_reg   <= 1'b0;
			ack_reg   <= 1'b0;
		end else begin
			ack_reg <= 1'b0;
			if (start) begin
				err_reg <= !dec_ok;
				if (dec_ok) begin
					state_reg <= BMX_S_RUN;
					kind_reg  <= dec_swp ? BMX_K_SWAP : opc[3] ? BMX_K_MVD
						: opc[0] ? BMX_K_SCI : BMX_K_MVI;
					rpt_reg   <= opc[4] && !dec_swp;
					mc_reg    <= 3'h0;
					t_reg     <= 3'h1;
					tsum_reg  <= 5'h01;
				end
			end else if (busy) begin
				tsum_reg <= (mc_end && last_mc) ? tsum_reg : tsum_reg + 5'h01;
				if (!mc_end) begin
					t_reg <= t_reg + 3'h1;
				end else if (!last_mc) begin
					t_reg  <= 3'h1;
					mc_reg <= mc_reg + 3'h1;
				end else if (blk && mc_reg == BMX_MC_BLK_RPT && !irq_req) begin
					t_reg    <= 3'h1;	// Re-execute from the opcode fetch
					mc_reg   <= 3'h0;
					tsum_reg <= 5'h01;
				end else begin
					state_reg <= BMX_S_IDLE;
					ack_reg   <= blk && (mc_reg == BMX_MC_BLK_RPT);
				end
			end
		end
	end

	// Data path: register file and memory transfers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_reg <= 16'h0000;
			dst_reg <= 16'h0000;
			cnt_reg <= 16'h0000;
			iy_reg  <= 16'h0000;
			sp_reg  <= 16'h0000;
			pc_reg  <= 16'h0000;
			acc_reg <= 8'h00;
			flg_reg <= 8'h00;
			lo_reg  <= 8'h00;
			hi_reg  <= 8'h00;
		end else if (sw) begin
			case (wa8)
				BMX_OFS_SRC:   src_reg <= wd16;
				BMX_OFS_DST:   dst_reg <= wd16;
				BMX_OFS_CNT:   cnt_reg <= wd16;
				BMX_OFS_IDXY:  iy_reg  <= wd16;
				BMX_OFS_STACK: sp_reg  <= wd16;
				BMX_OFS_PC:    pc_reg  <= wd16;
				BMX_OFS_ACCF: begin
					acc_reg <= wd16[15:8];
					flg_reg <= wd16[7:0];
				end
				default: begin
				end
			endcase
		end else if (mc_end) begin
			// Opcode fetch cycles advance the program counter
			if (mc_reg == 3'h0 || mc_reg == 3'h1) begin
				pc_reg <= pc_reg + 16'h0001;
			end
			if (is_swap) begin
				case (mc_reg)
					3'h2: lo_reg <= mem_rdata;
					3'h3: hi_reg <= mem_rdata;
					3'h5: iy_reg <= {hi_reg, lo_reg};
					default: begin
					end
				endcase
			end else if (mc_reg == 3'h2) begin
				lo_reg <= mem_rdata;
			end else if (mc_reg == 3'h3) begin
				src_reg <= src_nxt;
				dst_reg <= is_cmp ? dst_reg : dst_nxt;
				cnt_reg <= cnt_dec;
				flg_reg <= is_cmp ? f_cp : f_mv;
				if (go_on) begin
					pc_reg <= pc_reg - BMX_PC_BACK;
				end
			end
		end
	end
endmodule
`default_nettype wire
